/* hdl/cal_cmd_pkg.sv */
// Shared constants and types of the calibration and power command decoder.
// Assumes a 24-bit conversion result path and single-byte opcodes.
package cal_cmd_pkg;
   localparam int RES_W = 24;

   // Opcodes handled here
   localparam logic [7:0] OP_READ_CONT       = 8'h03;
   localparam logic [7:0] OP_STOP_CONT       = 8'h0F;
   localparam logic [7:0] OP_OFFSET_SELF_CAL = 8'hF1;
   localparam logic [7:0] OP_GAIN_SELF_CAL   = 8'hF2;
   localparam logic [7:0] OP_SYS_OFFSET_CAL  = 8'hF3;
   localparam logic [7:0] OP_SYS_GAIN_CAL    = 8'hF4;
   localparam logic [7:0] OP_WAKEUP          = 8'hFB;
   localparam logic [7:0] OP_SYNC_READY      = 8'hFC;
   localparam logic [7:0] OP_SLEEP           = 8'hFD;
   localparam logic [7:0] OP_RESET           = 8'hFE;

   // Power-up values of the calibration registers
   localparam logic [RES_W-1:0] OFFSET_RESET     = 24'h000000;
   localparam logic [RES_W-1:0] FULL_SCALE_RESET = 24'h400000;
   // Code the converter should report when input equals reference
   localparam logic [RES_W-1:0] FULL_SCALE_TARGET = 24'h400000;

   // Settling wait before a calibration sample is taken
   localparam int CAL_SETTLE_CYCLES = 64;
   localparam int BIT_CNT_W         = 3;
   localparam int RES_CNT_W         = 5;

   // Analog input selection requested by the calibration engine
   typedef enum logic [1:0] {
      IN_NORMAL    = 2'h0,
      IN_SHORTED   = 2'h1,
      IN_REFERENCE = 2'h2,
      IN_SYSTEM    = 2'h3
   } cal_input_t;

   // Gray-coded along idle, settle, capture
   typedef enum logic [1:0] {
      CAL_IDLE    = 2'h0,
      CAL_SETTLE  = 2'h1,
      CAL_CAPTURE = 2'h3
   } cal_state_t;

   typedef struct packed {
      logic [RES_W-1:0] offset;
      logic [RES_W-1:0] full_scale;
   } cal_regs_t;
endpackage

/* hdl/serial_byte_rx.sv */
// Assembles bytes from the serial data line, MSB first.
// Assumes synchronised inputs and a one-cycle sclk rising-edge pulse.
`timescale 1ns/10ps
module serial_byte_rx
   import cal_cmd_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       select,
   input  wire logic       sclk_rise,
   input  wire logic       din,
   output logic            byte_valid,
   output logic [7:0]      byte_data
);
   logic [6:0]           shift_q;
   logic [BIT_CNT_W-1:0] cnt_q;
   logic                 last_bit;

   assign last_bit = (cnt_q == 3'h7);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_q    <= 7'h00;
         cnt_q      <= 3'h0;
         byte_valid <= 1'b0;
         byte_data  <= 8'h00;
      end else begin
         byte_valid <= 1'b0;
         // Deselect realigns framing to the next byte boundary
         if (!select) begin
            cnt_q <= 3'h0;
         end else if (sclk_rise) begin
            shift_q <= {shift_q[5:0], din};
            cnt_q   <= cnt_q + 3'h1;
            if (last_bit) begin
               byte_valid <= 1'b1;
               byte_data  <= {shift_q, din};
            end
         end
      end
   end
endmodule

/* hdl/cal_power_decoder.sv */
// Command decoder for calibration, sleep, ready sync, reset and
// continuous read. Pins arrive asynchronously; measurement and result
// inputs come from converter logic on REF_CLK.
//
// Function
// - Gain self calibration measures the reference and reloads full scale.
// - System offset calibration cancels measured offset in the offset reg.
// - System gain calibration cancels gain error in the full scale reg.
// - The sync opcode realigns conversion and ready to the next sclk rising edge.
// - The sleep opcode enters low power and stays until wakeup.
// - The wakeup opcode ends sleep and resumes normal operation.
// - The reset opcode returns every configuration register to power-up.
// - The reset opcode also ends continuous read mode.
// - The reset opcode leaves RAM contents untouched.
// - Continuous read shifts out each result that arrives on ready while selected and awake, until stop or reset.
// - Offset self calibration updates only the offset register.
`timescale 1ns/10ps
module cal_power_decoder
   import cal_cmd_pkg::*;
#(
   parameter int SETTLE_CYCLES = CAL_SETTLE_CYCLES
)(
   input  wire logic             REF_CLK,
   input  wire logic             RESET_N,
   input  wire logic             SCLK,
   input  wire logic             DIN,
   input  wire logic             CS_N,
   input  wire logic             MEAS_VALID,
   input  wire logic [RES_W-1:0] MEAS_DATA,
   input  wire logic             RESULT_READY,
   input  wire logic [RES_W-1:0] RESULT_DATA,
   output logic                  DOUT,
   output logic                  DOUT_OE,
   output logic                  RESULT_READY_FLAG_N,
   output logic [RES_W-1:0]      OFFSET_CAL_REGISTER,
   output logic [RES_W-1:0]      FULL_SCALE_REGISTER,
   output cal_input_t            CAL_INPUT,
   output logic                  CAL_BUSY,
   output logic                  SLEEP_MODE,
   output logic                  CONT_READ_MODE,
   output logic                  CONV_SYNC,
   output logic                  CONFIG_RESET
);
   logic [2:0] sclk_sync_q;
   logic [1:0] din_sync_q;
   logic [1:0] cs_sync_q;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       selected;
   logic       byte_valid;
   logic [7:0] byte_data;

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sclk_sync_q <= 3'h0;
         din_sync_q  <= 2'h0;
         cs_sync_q   <= 2'h3;
      end else begin
         sclk_sync_q <= {sclk_sync_q[1:0], SCLK};
         din_sync_q  <= {din_sync_q[0], DIN};
         cs_sync_q   <= {cs_sync_q[0], CS_N};
      end
   end

   assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
   assign sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
   assign selected  = ~cs_sync_q[1];

   serial_byte_rx u_rx (
      .clk        (REF_CLK),
      .rst_n      (RESET_N),
      .select     (selected),
      .sclk_rise  (sclk_rise),
      .din        (din_sync_q[1]),
      .byte_valid (byte_valid),
      .byte_data  (byte_data)
   );

   // Opcode decode; in sleep only wakeup is honoured
   logic sleep_q;
   logic awake_cmd;
   logic is_gain_self;
   logic is_offset_self;
   logic is_sys_offset;
   logic is_sys_gain;
   logic is_sleep;
   logic is_wakeup;
   logic is_sync;
   logic is_reset;
   logic is_cont;
   logic is_stop;
   logic cal_start;

   assign awake_cmd      = byte_valid & ~sleep_q;
   assign is_gain_self   = awake_cmd & (byte_data == OP_GAIN_SELF_CAL);
   assign is_offset_self = awake_cmd & (byte_data == OP_OFFSET_SELF_CAL);
   assign is_sys_offset  = awake_cmd & (byte_data == OP_SYS_OFFSET_CAL);
   assign is_sys_gain    = awake_cmd & (byte_data == OP_SYS_GAIN_CAL);
   assign is_sleep       = awake_cmd & (byte_data == OP_SLEEP);
   assign is_sync        = awake_cmd & (byte_data == OP_SYNC_READY);
   assign is_reset       = awake_cmd & (byte_data == OP_RESET);
   assign is_cont        = awake_cmd & (byte_data == OP_READ_CONT);
   assign is_stop        = awake_cmd & (byte_data == OP_STOP_CONT);
   assign is_wakeup      = byte_valid & sleep_q & (byte_data == OP_WAKEUP);
   // Any other byte matches nothing above and so changes nothing
   assign cal_start      = is_gain_self | is_offset_self
                         | is_sys_offset | is_sys_gain;

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sleep_q <= 1'b0;
      end else if (is_sleep) begin
         sleep_q <= 1'b1;
      end else if (is_wakeup) begin
         sleep_q <= 1'b0;
      end
   end

   // Pulse for the external configuration registers; no RAM strobe exists
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         CONFIG_RESET <= 1'b0;
      end else begin
         CONFIG_RESET <= is_reset;
      end
   end

   // Calibration engine
   localparam int SET_W = $clog2(SETTLE_CYCLES + 1);
   localparam logic [SET_W-1:0] SETTLE_LAST = SET_W'(SETTLE_CYCLES - 1);

   cal_state_t       cal_state_q;
   cal_state_t       cal_state_d;
   cal_input_t       cal_in_q;
   logic             cal_gain_q;
   logic [SET_W-1:0] settle_q;
   cal_regs_t        regs_q;
   cal_regs_t        regs_d;
   logic             capture;
   logic [RES_W-1:0] offset_new;
   logic [RES_W-1:0] full_scale_new;

   assign capture        = (cal_state_q == CAL_CAPTURE) & MEAS_VALID;
   assign offset_new     = regs_q.offset - MEAS_DATA;
   assign full_scale_new = regs_q.full_scale + (FULL_SCALE_TARGET - MEAS_DATA);

   always_comb begin
      cal_state_d = cal_state_q;
      case (cal_state_q)
         CAL_IDLE:    if (cal_start) cal_state_d = CAL_SETTLE;
         CAL_SETTLE:  if (settle_q == SETTLE_LAST) cal_state_d = CAL_CAPTURE;
         CAL_CAPTURE: if (MEAS_VALID) cal_state_d = CAL_IDLE;
         default:     cal_state_d = CAL_IDLE;
      endcase
      if (is_reset) begin
         cal_state_d = CAL_IDLE;
      end
   end

   always_comb begin
      regs_d = regs_q;
      if (is_reset) begin
         regs_d.offset     = OFFSET_RESET;
         regs_d.full_scale = FULL_SCALE_RESET;
      end else if (capture && cal_gain_q) begin
         regs_d.full_scale = full_scale_new;
      end else if (capture) begin
         regs_d.offset = offset_new;
      end
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cal_state_q <= CAL_IDLE;
         regs_q      <= '{offset: OFFSET_RESET, full_scale: FULL_SCALE_RESET};
      end else begin
         cal_state_q <= cal_state_d;
         regs_q      <= regs_d;
      end
   end

   // A new calibration opcode while one runs is ignored
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cal_in_q   <= IN_NORMAL;
         cal_gain_q <= 1'b0;
         settle_q   <= '0;
      end else if (cal_state_q == CAL_IDLE && cal_start) begin
         settle_q   <= '0;
         cal_gain_q <= is_gain_self | is_sys_gain;
         if (is_gain_self) begin
            cal_in_q <= IN_REFERENCE;
         end else if (is_offset_self) begin
            cal_in_q <= IN_SHORTED;
         end else begin
            cal_in_q <= IN_SYSTEM;
         end
      end else if (cal_state_d == CAL_IDLE) begin
         cal_in_q <= IN_NORMAL;
      end else if (cal_state_q == CAL_SETTLE) begin
         settle_q <= settle_q + SET_W'(1);
      end
   end

   // Ready sync: armed by the opcode, fires on the next sclk rising edge
   logic sync_arm_q;
   logic sync_fire;

   assign sync_fire = sync_arm_q & sclk_rise;

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sync_arm_q <= 1'b0;
         CONV_SYNC  <= 1'b0;
      end else begin
         CONV_SYNC <= sync_fire;
         if (is_sync) begin
            sync_arm_q <= 1'b1;
         end else if (sync_fire || is_reset) begin
            sync_arm_q <= 1'b0;
         end
      end
   end

   // Continuous read and result shifter
   logic                 cont_q;
   logic                 ready_q;
   logic [RES_W-1:0]     out_shift_q;
   logic [RES_CNT_W-1:0] out_left_q;
   logic                 shifting;
   logic                 out_load;

   assign shifting = (out_left_q != '0);
   assign out_load = RESULT_READY & cont_q & ~sleep_q;

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cont_q <= 1'b0;
      end else if (is_stop || is_reset) begin
         cont_q <= 1'b0;
      end else if (is_cont) begin
         cont_q <= 1'b1;
      end
   end

   // Ready flag: a new result wins over a clear in the same cycle
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ready_q <= 1'b0;
      end else if (RESULT_READY) begin
         ready_q <= 1'b1;
      end else if (sync_fire || is_reset || (shifting && out_left_q == 5'h01
                                             && sclk_fall)) begin
         ready_q <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         out_shift_q <= '0;
         out_left_q  <= '0;
      end else if (is_reset || !selected) begin
         out_left_q <= '0;
      end else if (out_load) begin
         out_shift_q <= RESULT_DATA;
         out_left_q  <= RES_CNT_W'(RES_W);
      end else if (shifting && sclk_fall) begin
         out_shift_q <= {out_shift_q[RES_W-2:0], 1'b0};
         out_left_q  <= out_left_q - 5'h01;
      end
   end

   assign DOUT                = out_shift_q[RES_W-1];
   assign DOUT_OE             = shifting & selected;
   assign RESULT_READY_FLAG_N = ~ready_q;
   assign OFFSET_CAL_REGISTER = regs_q.offset;
   assign FULL_SCALE_REGISTER = regs_q.full_scale;
   assign CAL_INPUT           = cal_in_q;
   assign CAL_BUSY            = (cal_state_q != CAL_IDLE);
   assign SLEEP_MODE          = sleep_q;
   assign CONT_READ_MODE      = cont_q;
endmodule

/* tb/host_link_model.sv */
// Host side of the serial link: select, serial clock and data line.
// Assumes the bench clock at 8 ns; each half of the serial clock is 80 ns.
`timescale 1ns/10ps
module host_link_model (
   input  wire logic clk,
   input  wire logic dout,
   output logic      sclk,
   output logic      din,
   output logic      cs_n
);
   initial begin
      sclk = 1'b0;
      din  = 1'b1;
      cs_n = 1'b1;
   end
   task automatic half();
      repeat (10) @(negedge clk);
   endtask
   // Select stays low across calls so a multi-byte readout is not aborted
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      cs_n = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         din = tx[i];
         half();
         rx[i] = dout;
         sclk = 1'b1;
         half();
         sclk = 1'b0;
      end
   endtask
   // Select without clocking, so a result can load before readout
   task automatic open_frame();
      cs_n = 1'b0;
      half();
   endtask
   // Clock stands still outside frames, so sleep sees no edges
   task automatic close();
      half();
      cs_n = 1'b1;
      din  = ~din;
      half();
   endtask
endmodule

/* tb/cal_power_decoder_properties.sv */
// Concurrent checks on the ports of the command decoder.
// Assumes one clock domain, REF_CLK, with RESET_N asynchronous.
`timescale 1ns/10ps
module cal_power_decoder_properties
   import cal_cmd_pkg::*;
(
   input wire logic             REF_CLK,
   input wire logic             RESET_N,
   input wire logic             RESULT_READY,
   input wire logic             DOUT_OE,
   input wire logic             RESULT_READY_FLAG_N,
   input wire logic [RES_W-1:0] OFFSET_CAL_REGISTER,
   input wire logic [RES_W-1:0] FULL_SCALE_REGISTER,
   input wire cal_input_t       CAL_INPUT,
   input wire logic             CAL_BUSY,
   input wire logic             SLEEP_MODE,
   input wire logic             CONT_READ_MODE,
   input wire logic             CONV_SYNC,
   input wire logic             CONFIG_RESET
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);

   reset_restore_a: assert property (CONFIG_RESET |=>
      OFFSET_CAL_REGISTER == OFFSET_RESET && !CONT_READ_MODE &&
      FULL_SCALE_REGISTER == FULL_SCALE_RESET && !CAL_BUSY)
      else $error("reset opcode left state behind");
   reset_pulse_a: assert property (CONFIG_RESET |=> !CONFIG_RESET)
      else $error("config reset longer than one cycle");
   sync_pulse_a: assert property ($rose(CONV_SYNC) |=> !CONV_SYNC)
      else $error("sync pulse longer than one cycle");
   sleep_hold_a: assert property (SLEEP_MODE && $past(SLEEP_MODE) |->
      $stable(OFFSET_CAL_REGISTER) && $stable(CONT_READ_MODE) && !CONFIG_RESET)
      else $error("state changed while asleep");
   offset_cause_a: assert property (
      $changed(OFFSET_CAL_REGISTER) |->
      $past(CAL_BUSY) || CONFIG_RESET || $past(CONFIG_RESET))
      else $error("offset changed without calibration");
   scale_cause_a: assert property (
      $changed(FULL_SCALE_REGISTER) |->
      $past(CAL_BUSY) || CONFIG_RESET || $past(CONFIG_RESET))
      else $error("full scale changed without calibration");
   cal_select_a: assert property (CAL_BUSY == (CAL_INPUT != IN_NORMAL))
      else $error("input select disagrees with busy");
   stream_mode_a: assert property ($rose(DOUT_OE) |-> CONT_READ_MODE)
      else $error("result shifted outside continuous read");
   ready_flag_a: assert property (RESULT_READY && CONT_READ_MODE &&
      !SLEEP_MODE |=> !RESULT_READY_FLAG_N)
      else $error("ready flag not set on new result");

   cover property ($fell(CAL_BUSY));
   cover property ($rose(SLEEP_MODE));
   cover property ($rose(DOUT_OE));
   cover property (CONFIG_RESET);
endmodule

bind cal_power_decoder cal_power_decoder_properties
   cal_power_decoder_properties_i (.REF_CLK, .RESET_N, .RESULT_READY,
   .DOUT_OE, .RESULT_READY_FLAG_N, .OFFSET_CAL_REGISTER,
   .FULL_SCALE_REGISTER, .CAL_INPUT, .CAL_BUSY, .SLEEP_MODE,
   .CONT_READ_MODE, .CONV_SYNC, .CONFIG_RESET);

/* tb/adc_cal_power_command_decoder_bench.sv */
// Self-checking bench for the calibration and power command decoder.
// Assumes the host model drives the serial pins; settle count set to 4.
`timescale 1ns/10ps
module adc_cal_power_command_decoder_bench
   import cal_cmd_pkg::*;
;
   typedef struct packed {
      logic [7:0]  op;
      logic [23:0] meas;
      logic [23:0] off;
      logic [23:0] fs;
      logic [1:0]  inp;
   } row_t;
   logic ref_clk = 1'b0, reset_n = 1'b0, meas_valid = 1'b0;
   logic result_ready = 1'b0;
   logic [23:0] meas_data = 24'h0, result_data = 24'h0;
   logic sclk, din, cs_n, dout, dout_oe, flag_n, busy, sleep, cont;
   logic conv_sync, cfg_reset;
   logic [23:0] offset, full_scale, n_sync = 24'h0, n_cfg = 24'h0;
   logic [7:0] r0, r1, r2;
   cal_input_t cal_input;
   int err_total = 0, n_checks = 0;
   // Bench stands in for the inputs: small codes for offset, codes near reference for gain
   row_t rows [6] = '{
      '{OP_OFFSET_SELF_CAL, 24'h000010, 24'hFFFFF0, 24'h400000, 2'h1},
      '{OP_SYS_OFFSET_CAL, 24'h000005, 24'hFFFFEB, 24'h400000, 2'h3},
      '{OP_GAIN_SELF_CAL, 24'h3FFFF0, 24'hFFFFEB, 24'h400010, 2'h2},
      '{OP_SYS_GAIN_CAL, 24'h400020, 24'hFFFFEB, 24'h3FFFF0, 2'h3},
      '{8'hAA, 24'h123456, 24'hFFFFEB, 24'h3FFFF0, 2'h0},
      '{8'h30, 24'h000001, 24'hFFFFEB, 24'h3FFFF0, 2'h0}};

   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (conv_sync === 1'b1) n_sync <= n_sync + 24'h1;
      if (cfg_reset === 1'b1) n_cfg <= n_cfg + 24'h1;
   end

   host_link_model host_link_model_i (.clk(ref_clk), .dout(dout),
      .sclk(sclk), .din(din), .cs_n(cs_n));
   cal_power_decoder #(.SETTLE_CYCLES(4)) cal_power_decoder_i (
      .REF_CLK(ref_clk), .RESET_N(reset_n), .SCLK(sclk), .DIN(din),
      .CS_N(cs_n), .MEAS_VALID(meas_valid), .MEAS_DATA(meas_data),
      .RESULT_READY(result_ready), .RESULT_DATA(result_data), .DOUT(dout),
      .DOUT_OE(dout_oe), .RESULT_READY_FLAG_N(flag_n),
      .OFFSET_CAL_REGISTER(offset), .FULL_SCALE_REGISTER(full_scale),
      .CAL_INPUT(cal_input), .CAL_BUSY(busy), .SLEEP_MODE(sleep),
      .CONT_READ_MODE(cont), .CONV_SYNC(conv_sync), .CONFIG_RESET(cfg_reset));

   task automatic check_word(string nm, logic [23:0] e, logic [23:0] s);
      n_checks++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic check_flag(string nm, logic e, logic s);
      check_word(nm, {23'h0, e}, {23'h0, s});
   endtask
   task automatic cmd(logic [7:0] b);
      logic [7:0] r;
      host_link_model_i.xfer(b, r);
      host_link_model_i.close();
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #300us;
      err_total++;
      give_verdict();
   end

   initial begin
      repeat (20) @(negedge ref_clk);
      reset_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      check_word("offset", OFFSET_RESET, offset);
      check_word("full_scale", FULL_SCALE_RESET, full_scale);
      check_flag("ready_n", 1'b1, flag_n);
      foreach (rows[k]) begin
         cmd(rows[k].op);
         check_word("cal_input", 24'(rows[k].inp),
                    24'(cal_input));
         check_flag("busy", rows[k].inp != 2'h0,
                    busy);
         meas_data  = rows[k].meas;
         meas_valid = 1'b1;
         @(negedge ref_clk) meas_valid = 1'b0;
         repeat (3) @(negedge ref_clk);
         check_word("offset", rows[k].off, offset);
         check_word("full_scale", rows[k].fs, full_scale);
         check_flag("busy", 1'b0, busy);
      end
      cmd(OP_SLEEP);
      check_flag("sleep", 1'b1, sleep);
      cmd(OP_WAKEUP);
      check_flag("sleep", 1'b0, sleep);
      check_word("sync_pulses", 24'h0, n_sync);
      cmd(OP_SYNC_READY);
      cmd(8'h00);
      check_word("sync_pulses", 24'h1, n_sync);
      cmd(OP_READ_CONT);
      check_flag("cont", 1'b1, cont);
      // Select first: the decoder drops a result that finds CS_N high
      host_link_model_i.open_frame();
      result_data  = 24'hA5C3E1;
      result_ready = 1'b1;
      @(negedge ref_clk) result_ready = 1'b0;
      repeat (2) @(negedge ref_clk);
      check_flag("ready_n", 1'b0, flag_n);
      host_link_model_i.xfer(8'h00, r0);
      host_link_model_i.xfer(8'h00, r1);
      host_link_model_i.xfer(8'h00, r2);
      host_link_model_i.close();
      check_word("result", 24'hA5C3E1, {r0, r1, r2});
      check_flag("ready_n", 1'b1, flag_n);
      check_flag("dout_oe", 1'b0, dout_oe);
      cmd(OP_STOP_CONT);
      check_flag("cont", 1'b0, cont);
      host_link_model_i.open_frame();
      result_ready = 1'b1;
      @(negedge ref_clk) result_ready = 1'b0;
      repeat (2) @(negedge ref_clk);
      check_flag("dout_oe", 1'b0, dout_oe);
      host_link_model_i.close();
      cmd(OP_READ_CONT);
      check_flag("cont", 1'b1, cont);
      cmd(OP_OFFSET_SELF_CAL);
      check_flag("busy", 1'b1, busy);
      cmd(OP_RESET);
      check_flag("cont", 1'b0, cont);
      check_flag("busy", 1'b0, busy);
      check_word("offset", OFFSET_RESET, offset);
      check_word("full_scale", FULL_SCALE_RESET, full_scale);
      check_word("config_resets", 24'h1, n_cfg);
      check_flag("ready_n", 1'b1, flag_n);
      give_verdict();
   end
endmodule
